/* hdl/rdsr_baud_tick.sv */
`timescale 1ns/1ps
module rdsr_baud_tick
   import rdsr_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   // rate choice
   input  wire logic fast_sel,
   // one-cycle bit-rate enable
   output logic      tick_r
);

   logic [BAUD_DIV_W-1:0] count_r;
   wire  [BAUD_DIV_W-1:0] div_last;
   wire                   wrap;

   assign div_last = fast_sel ? BAUD_HIGH_DIV - 11'h001 : BAUD_LOW_DIV - 11'h001;
   // >= so that a switch to the short divisor never overruns the counter
   assign wrap     = (count_r >= div_last);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         count_r <= '0;
         tick_r  <= 1'b0;
      end else begin
         count_r <= wrap ? '0 : count_r + 11'h001;
         tick_r  <= wrap;
      end
   end

endmodule : rdsr_baud_tick

/* hdl/rdsr_pkg.sv */
package rdsr_pkg;

   // ----------------------------------------
   // command classes and indices
   // ----------------------------------------
   localparam logic [7:0] CLASS_READ      = 8'h52;
   localparam logic [7:0] CLASS_WRITE     = 8'h57;
   localparam logic [7:0] CLASS_DET       = 8'h44;
   localparam logic [7:0] IDX_FLAGS       = 8'h00;
   localparam logic [7:0] IDX_SPEED       = 8'h01;
   localparam logic [7:0] IDX_MAG         = 8'h02;
   localparam logic [7:0] IDX_NOISE       = 8'h03;
   localparam logic [7:0] IDX_OP_STATE    = 8'h04;
   localparam logic [7:0] IDX_HOLD_POT    = 8'h05;
   localparam logic [7:0] IDX_SENS_POT    = 8'h06;
   localparam logic [7:0] IDX_SOFT_RESET  = 8'h00;
   localparam logic [7:0] IDX_RESTORE     = 8'h01;
   localparam logic [7:0] IDX_BAUD        = 8'h02;
   localparam logic [7:0] IDX_SPLIT_THR   = 8'h06;

   // ----------------------------------------
   // fields, encodings, reset values
   // ----------------------------------------
   localparam int         FLAG_VALID_BIT  = 0;
   localparam int         FLAG_DIR_BIT    = 1;
   localparam int         FLAG_RANGE_BIT  = 2;
   localparam int         FLAG_MICRO_BIT  = 3;
   localparam logic [7:0] REG_RST         = 8'h00;
   localparam logic [7:0] OPST_STARTUP    = 8'h00;
   localparam logic [7:0] OPST_LEARN      = 8'h01;
   localparam logic [7:0] OPST_RUN        = 8'h02;
   localparam logic [7:0] BAUD_SEL_LOW    = 8'h00;
   localparam logic [7:0] BAUD_SEL_HIGH   = 8'h01;
   localparam logic [7:0] BAUD_SEL_RST    = BAUD_SEL_LOW;
   localparam logic [6:0] SPLIT_THR_RST   = 7'h00;
   localparam logic [7:0] SPLIT_THR_MAX   = 8'h7f;
   localparam logic [7:0] POT_IDX_MAX     = 8'h09;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int          CLK_HZ         = 50_000_000;
   localparam int          BAUD_LOW_BPS   = 38_400;
   localparam int          BAUD_HIGH_BPS  = 460_800;
   localparam int          BAUD_DIV_W     = 11;
   localparam logic [10:0] BAUD_LOW_DIV   = 11'(CLK_HZ / BAUD_LOW_BPS);
   localparam logic [10:0] BAUD_HIGH_DIV  = 11'(CLK_HZ / BAUD_HIGH_BPS);

   // ----------------------------------------
   // potentiometer conversion
   // ----------------------------------------
   localparam int          ADC_W          = 12;
   localparam int          ADC_REF_MV     = 3300;
   localparam int          POT_TOP_MV     = 3000;
   localparam int          ADC_FULL_CODE  = 4095;
   localparam logic [11:0] POT_TOP_CODE   = 12'((ADC_FULL_CODE * POT_TOP_MV) / ADC_REF_MV);
   localparam logic [11:0] POT_STEP_CODE  = 12'(POT_TOP_CODE / 9);

endpackage : rdsr_pkg

/* hdl/rdsr_pot_index.sv */
`timescale 1ns/1ps
module rdsr_pot_index
   import rdsr_pkg::*;
(
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   // converter sample from the analogue front end
   input  wire logic [ADC_W-1:0] adc_code,
   // quantised index
   output logic      [7:0]       index_r
);

   logic [ADC_W-1:0] sync1_r;
   logic [ADC_W-1:0] sync2_r;
   logic [ADC_W-1:0] sync3_r;
   logic [ADC_W-1:0] stable_r;
   logic [7:0]       index_nxt;

   // comes from another domain; only accepted once stages two and three agree
   always_ff @(posedge sys_clk) begin
      sync1_r <= adc_code;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sys_rst) begin
         stable_r <= '0;
      end else if (sync2_r == sync3_r) begin
         stable_r <= sync3_r;
      end
   end

   // count how many step marks the sample has passed, saturating at nine
   always_comb begin
      index_nxt = REG_RST;
      for (int k = 1; k <= 9; k++) begin
         if (stable_r >= 12'(k * POT_STEP_CODE)) begin
            index_nxt = 8'(k);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         index_r <= REG_RST;
      end else begin
         index_r <= index_nxt;
      end
   end

   a_pot_bound : assert property (@(posedge sys_clk) disable iff (sys_rst)
      index_r <= POT_IDX_MAX) else $error("pot index above nine");

endmodule : rdsr_pot_index

/* hdl/rdsr_regs.sv */
`timescale 1ns/1ps
module rdsr_regs
   import rdsr_pkg::*;
(
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   // parameter command from the serial command layer
   input  wire logic             cmd_valid,
   input  wire logic             cmd_write,
   input  wire logic [7:0]       cmd_class,
   input  wire logic [7:0]       cmd_index,
   input  wire logic [7:0]       cmd_wdata,
   // parameter answer
   output logic                  rsp_valid_r,
   output logic [7:0]            rsp_data_r,
   output logic                  rsp_error_r,
   // results of one processing cycle
   input  wire logic             proc_done,
   input  wire logic             det_valid,
   input  wire logic             det_forward,
   input  wire logic             det_micro,
   input  wire logic [7:0]       det_speed,
   input  wire logic [7:0]       det_mag,
   input  wire logic [7:0]       noise_level,
   input  wire logic [7:0]       proc_state,
   // analogue potentiometer samples
   input  wire logic [ADC_W-1:0] hold_adc,
   input  wire logic [ADC_W-1:0] sens_adc,
   // controls to the rest of the sensor
   output logic                  soft_reset_r,
   output logic                  restore_r,
   output logic                  baud_fast_r,
   output logic                  baud_tick_r,
   output logic [6:0]            split_thr_r
);

   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [7:0] flags_r;
   logic [7:0] speed_r;
   logic [7:0] mag_r;
   logic [7:0] noise_r;
   logic [7:0] op_state_r;
   logic [7:0] hold_idx;
   logic [7:0] sens_idx;
   logic [7:0] flags_nxt;
   logic       baud_fast_nxt;
   logic [6:0] split_thr_nxt;

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   wire is_rd      = cmd_valid & ~cmd_write;
   wire is_wr      = cmd_valid & cmd_write;
   wire cls_rd     = (cmd_class == CLASS_READ);
   wire cls_wr     = (cmd_class == CLASS_WRITE);
   wire cls_det    = (cmd_class == CLASS_DET);
   wire idx_thr    = (cmd_index == IDX_SPLIT_THR);

   wire wr_soft    = is_wr & cls_wr & (cmd_index == IDX_SOFT_RESET);
   wire wr_restore = is_wr & cls_wr & (cmd_index == IDX_RESTORE);
   wire wr_baud    = is_wr & cls_wr & (cmd_index == IDX_BAUD) & (cmd_wdata <= BAUD_SEL_HIGH);
   wire wr_thr     = is_wr & cls_det & idx_thr & (cmd_wdata <= SPLIT_THR_MAX);
   wire wr_ok      = wr_soft | wr_restore | wr_baud | wr_thr;

   wire rd_rt      = is_rd & cls_rd & (cmd_index <= IDX_SENS_POT);
   wire rd_thr     = is_rd & cls_det & idx_thr;
   wire rd_ok      = rd_rt | rd_thr;

   // anything else, including reads of write-only and out-of-range values
   wire cmd_bad    = cmd_valid & ~(rd_ok | wr_ok);

   // soft reset clears live state and the rate select for one cycle; the split threshold survives it
   wire live_rst   = sys_rst | soft_reset_r;

   // ----------------------------------------
   // read selection
   // ----------------------------------------
   wire [7:0] rt_mux =
      (cmd_index == IDX_FLAGS)    ? flags_r    :
      (cmd_index == IDX_SPEED)    ? speed_r    :
      (cmd_index == IDX_MAG)      ? mag_r      :
      (cmd_index == IDX_NOISE)    ? noise_r    :
      (cmd_index == IDX_OP_STATE) ? op_state_r :
      (cmd_index == IDX_HOLD_POT) ? hold_idx   :
      (cmd_index == IDX_SENS_POT) ? sens_idx   :
                                    REG_RST;
   wire [7:0] rd_data = rd_thr ? {1'b0, split_thr_r} : rt_mux;

   // ----------------------------------------
   // detection word
   // ----------------------------------------
   // high range means strictly above the threshold bin
   wire thr_on    = (split_thr_r != SPLIT_THR_RST);
   wire range_hit = det_valid & thr_on & (det_speed > {1'b0, split_thr_r});

   always_comb begin
      flags_nxt                 = REG_RST;
      flags_nxt[FLAG_VALID_BIT] = det_valid;
      flags_nxt[FLAG_DIR_BIT]   = det_valid & det_forward;
      flags_nxt[FLAG_RANGE_BIT] = range_hit;
      flags_nxt[FLAG_MICRO_BIT] = det_micro;
   end

   // ----------------------------------------
   // live registers
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (live_rst) begin
         flags_r    <= REG_RST;
         noise_r    <= REG_RST;
         op_state_r <= OPST_STARTUP;
      end else if (proc_done) begin
         flags_r    <= flags_nxt;
         noise_r    <= noise_level;
         op_state_r <= proc_state;
      end
   end

   // speed and magnitude keep the last valid hit across empty cycles
   always_ff @(posedge sys_clk) begin
      if (live_rst) begin
         speed_r <= REG_RST;
         mag_r   <= REG_RST;
      end else if (proc_done & det_valid) begin
         speed_r <= det_speed;
         mag_r   <= det_mag;
      end
   end

   // ----------------------------------------
   // write parameters
   // ----------------------------------------
   always_comb begin
      baud_fast_nxt = baud_fast_r;
      split_thr_nxt = split_thr_r;
      if (wr_baud) begin
         baud_fast_nxt = (cmd_wdata == BAUD_SEL_HIGH);
      end
      if (wr_thr) begin
         split_thr_nxt = cmd_wdata[6:0];
      end
      if (wr_restore) begin
         baud_fast_nxt = (BAUD_SEL_RST == BAUD_SEL_HIGH);
         split_thr_nxt = SPLIT_THR_RST;
      end
   end

   // rate select is volatile: both resets bring it back to the slow rate
   always_ff @(posedge sys_clk) begin
      if (live_rst) begin
         baud_fast_r <= 1'b0;
      end else begin
         baud_fast_r <= baud_fast_nxt;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         split_thr_r <= SPLIT_THR_RST;
      end else begin
         split_thr_r <= split_thr_nxt;
      end
   end

   // ----------------------------------------
   // command pulses and answer
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         soft_reset_r <= 1'b0;
         restore_r    <= 1'b0;
      end else begin
         soft_reset_r <= wr_soft;
         restore_r    <= wr_restore;
      end
   end

   // answer always one cycle after the command, whatever it was
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rsp_valid_r <= 1'b0;
         rsp_data_r  <= REG_RST;
         rsp_error_r <= 1'b0;
      end else begin
         rsp_valid_r <= cmd_valid;
         rsp_data_r  <= rd_ok ? rd_data : REG_RST;
         rsp_error_r <= cmd_bad;
      end
   end

   // ----------------------------------------
   // leaf instances
   // ----------------------------------------
   rdsr_pot_index u_hold_pot (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .adc_code (hold_adc),
      .index_r  (hold_idx)
   );

   rdsr_pot_index u_sens_pot (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .adc_code (sens_adc),
      .index_r  (sens_idx)
   );

   rdsr_baud_tick u_baud (
      .sys_clk  (sys_clk),
      .sys_rst  (live_rst),
      .fast_sel (baud_fast_r),
      .tick_r   (baud_tick_r)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_soft_cmd;
      cmd_valid && cmd_write && cmd_class == CLASS_WRITE && cmd_index == IDX_SOFT_RESET;
   endsequence

   sequence s_soft_done;
      soft_reset_r ##1 (!baud_fast_r && op_state_r == OPST_STARTUP && flags_r == REG_RST);
   endsequence

   sequence s_restore_cmd;
      cmd_valid && cmd_write && cmd_class == CLASS_WRITE && cmd_index == IDX_RESTORE;
   endsequence

   a_valid_capture : assert property (
      (proc_done && !soft_reset_r) |=> flags_r[FLAG_VALID_BIT] == $past(det_valid)
   ) else $error("valid bit not taken from processing");

   a_dir_gated : assert property (
      flags_r[FLAG_DIR_BIT] |-> flags_r[FLAG_VALID_BIT]
   ) else $error("direction set without detection");

   a_dir_value : assert property (
      (proc_done && !soft_reset_r) |=> flags_r[FLAG_DIR_BIT] == ($past(det_valid) && $past(det_forward))
   ) else $error("direction bit not taken from processing");

   a_range_gated : assert property (
      flags_r[FLAG_RANGE_BIT] |-> flags_r[FLAG_VALID_BIT]
   ) else $error("range bit set without detection");

   // threshold may change after capture, so the gate is judged at the capture edge
   a_range_off : assert property (
      (proc_done && !soft_reset_r && !(det_valid && thr_on)) |=> !flags_r[FLAG_RANGE_BIT]
   ) else $error("range bit set while disabled or idle");

   a_range_value : assert property (
      (proc_done && !soft_reset_r && det_valid && thr_on) |=>
         flags_r[FLAG_RANGE_BIT] == ($past(det_speed) > {1'b0, $past(split_thr_r)})
   ) else $error("range bit disagrees with threshold");

   a_micro_capture : assert property (
      (proc_done && !soft_reset_r) |=> flags_r[FLAG_MICRO_BIT] == $past(det_micro)
   ) else $error("micro bit not taken from processing");

   a_noise_take : assert property (
      (proc_done && !soft_reset_r) |=> noise_r == $past(noise_level)
   ) else $error("noise level not taken from processing");

   a_state_take : assert property (
      (proc_done && !soft_reset_r) |=> op_state_r == $past(proc_state)
   ) else $error("operation state not taken from processing");

   a_live_hold : assert property (
      (!proc_done && !soft_reset_r) |=> $stable(flags_r) && $stable(noise_r) && $stable(op_state_r)
   ) else $error("live register changed without a processing cycle");

   a_speed_hold : assert property (
      (proc_done && !det_valid && !soft_reset_r) |=> $stable(speed_r) && $stable(mag_r)
   ) else $error("speed or magnitude lost on empty cycle");

   a_speed_take : assert property (
      (proc_done && det_valid && !soft_reset_r) |=> speed_r == $past(det_speed) && mag_r == $past(det_mag)
   ) else $error("speed or magnitude not updated");

   a_soft_reset : assert property (
      s_soft_cmd |=> s_soft_done
   ) else $error("soft reset did not clear state and rate");

   a_soft_clears : assert property (
      soft_reset_r |=> speed_r == REG_RST && mag_r == REG_RST && noise_r == REG_RST
   ) else $error("soft reset left detection values");

   a_restore_all : assert property (
      s_restore_cmd |=> restore_r && split_thr_r == SPLIT_THR_RST && !baud_fast_r
   ) else $error("restore left a parameter changed");

   a_restore_pulse : assert property (
      restore_r |-> $past(wr_restore)
   ) else $error("restore pulse without a command");

   a_baud_select : assert property (
      (wr_baud && !soft_reset_r) |=> baud_fast_r == ($past(cmd_wdata) == BAUD_SEL_HIGH)
   ) else $error("rate select not applied");

   a_rate_refuse : assert property (
      (is_wr && cls_wr && cmd_index == IDX_BAUD && cmd_wdata > BAUD_SEL_HIGH && !soft_reset_r) |=>
         rsp_error_r && $stable(baud_fast_r)
   ) else $error("out-of-range rate accepted");

   a_baud_reset : assert property (
      soft_reset_r |=> !baud_fast_r
   ) else $error("rate survived a reset");

   a_rate_default : assert property (
      $fell(sys_rst) |-> !baud_fast_r
   ) else $error("rate not slow after reset");

   a_thr_write : assert property (
      wr_thr |=> split_thr_r == $past(cmd_wdata[6:0])
   ) else $error("threshold write not applied");

   a_thr_refuse : assert property (
      (is_wr && cls_det && idx_thr && cmd_wdata > SPLIT_THR_MAX) |=> rsp_error_r && $stable(split_thr_r)
   ) else $error("out-of-range threshold accepted");

   a_rsp_timing : assert property (
      cmd_valid |=> rsp_valid_r ##1 !rsp_valid_r || $past(cmd_valid)
   ) else $error("answer not one cycle after command");

   a_read_data : assert property (
      (rd_rt && cmd_index == IDX_OP_STATE) |=> rsp_data_r == $past(op_state_r) && !rsp_error_r
   ) else $error("state read returned wrong data");

   a_rd_flags : assert property (
      (rd_rt && cmd_index == IDX_FLAGS) |=> rsp_data_r == $past(flags_r) && !rsp_error_r
   ) else $error("flag read returned wrong data");

   a_rd_thr : assert property (
      rd_thr |=> rsp_data_r == {1'b0, $past(split_thr_r)} && !rsp_error_r
   ) else $error("threshold read returned wrong data");

endmodule : rdsr_regs

/* verification/rdsr_host_model.sv */
`timescale 1ns/1ps
module rdsr_host_model (
   // clock
   input  wire logic       sys_clk,
   // command to the block
   output logic            cmd_valid,
   output logic            cmd_write,
   output logic [7:0]      cmd_class,
   output logic [7:0]      cmd_index,
   output logic [7:0]      cmd_wdata,
   // answer from the block
   input  wire logic       rsp_valid_r,
   input  wire logic [7:0] rsp_data_r,
   input  wire logic       rsp_error_r
);
   logic [9:0] got;

   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_class = 8'h00;
      cmd_index = 8'h00;
      cmd_wdata = 8'h00;
      got       = 10'h000;
   end

   // one command per call; the answer is taken half a cycle after its edge
   task automatic send(input logic wr, input logic [7:0] cls, input logic [7:0] idx, input logic [7:0] wd);
      @(negedge sys_clk);
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_class = cls;
      cmd_index = idx;
      cmd_wdata = wd;
      @(negedge sys_clk);
      got       = {rsp_valid_r, rsp_error_r, rsp_data_r};
      cmd_valid = 1'b0;
      // idle lines carry inverted values so a stale decode cannot match
      cmd_write = ~wr;
      cmd_class = ~cls;
      cmd_index = ~idx;
      cmd_wdata = ~wd;
   endtask : send
endmodule : rdsr_host_model

/* verification/tb.sv */
`timescale 1ns/1ps
module tb
   import rdsr_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        cmd_valid, cmd_write, rsp_valid_r, rsp_error_r;
   logic [7:0]  cmd_class, cmd_index, cmd_wdata, rsp_data_r;
   logic        proc_done = 1'b0, det_valid = 1'b0, det_forward = 1'b0, det_micro = 1'b0;
   logic [7:0]  det_speed = 8'h00, det_mag = 8'h00, noise_level = 8'h00, proc_state = 8'h00;
   logic [11:0] hold_adc = 12'h000, sens_adc = 12'h000;
   logic        soft_reset_r, restore_r, baud_fast_r, baud_tick_r;
   logic [6:0]  split_thr_r;
   logic [31:0] seed = 32'ha9cae6b2;
   int          n_fail = 0, n_compared = 0, cycles = 0;
   logic [7:0]  last_sp = 8'h00, last_mg = 8'h00;
   logic [6:0]  thr = 7'h00;
   logic [11:0] pot_codes [6] = '{12'h000, 12'h19c, 12'h19d, 12'he84, 12'he85, 12'hfff};

   always #10 sys_clk = ~sys_clk;

   rdsr_regs uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_class(cmd_class), .cmd_index(cmd_index), .cmd_wdata(cmd_wdata), .rsp_valid_r(rsp_valid_r),
      .rsp_data_r(rsp_data_r), .rsp_error_r(rsp_error_r), .proc_done(proc_done), .det_valid(det_valid),
      .det_forward(det_forward), .det_micro(det_micro), .det_speed(det_speed), .det_mag(det_mag),
      .noise_level(noise_level), .proc_state(proc_state), .hold_adc(hold_adc), .sens_adc(sens_adc),
      .soft_reset_r(soft_reset_r), .restore_r(restore_r), .baud_fast_r(baud_fast_r),
      .baud_tick_r(baud_tick_r), .split_thr_r(split_thr_r));

   rdsr_host_model host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_class(cmd_class), .cmd_index(cmd_index), .cmd_wdata(cmd_wdata),
      .rsp_valid_r(rsp_valid_r), .rsp_data_r(rsp_data_r), .rsp_error_r(rsp_error_r));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic [7:0] exp_flags(input logic v, input logic f, input logic m, input logic [7:0] sp);
      return {4'h0, m, v & (thr != 7'h00) & (sp > {1'b0, thr}), v & f, v};
   endfunction : exp_flags

   function automatic logic [7:0] exp_pot(input logic [11:0] code);
      logic [11:0] q;
      q = code / POT_STEP_CODE;
      return (q > 12'h009) ? POT_IDX_MAX : q[7:0];
   endfunction : exp_pot

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic rd(input logic [7:0] cls, input logic [7:0] idx, input logic [7:0] exp);
      host.send(1'b0, cls, idx, 8'h00);
      check(16'(host.got), {6'h00, 2'b10, exp});
   endtask : rd

   task automatic wr(input logic [7:0] cls, input logic [7:0] idx, input logic [7:0] wd, input logic err);
      host.send(1'b1, cls, idx, wd);
      check(16'(host.got), {6'h00, 1'b1, err, 8'h00});
   endtask : wr

   task automatic proc(input logic [7:0] st);
      seed = lfsr(seed);
      @(negedge sys_clk);
      proc_done = 1'b1;
      {det_valid, det_forward, det_micro} = seed[2:0];
      det_speed = (seed[4:3] == 2'b00) ? {1'b0, thr} : (seed[4:3] == 2'b01) ? {1'b0, thr} + 8'h01 : seed[15:8];
      det_mag = seed[23:16];
      noise_level = seed[31:24];
      proc_state = st;
      @(negedge sys_clk);
      proc_done = 1'b0;
      if (det_valid) begin
         last_sp = det_speed;
         last_mg = det_mag;
      end
   endtask : proc

   task automatic tick_period(input int exp);
      int n;
      n = 0;
      repeat (2) begin
         while (baud_tick_r !== 1'b1 && n < 4000) begin
            @(negedge sys_clk);
            n++;
         end
         @(negedge sys_clk);
      end
      n = 1;
      while (baud_tick_r !== 1'b1 && n < 4000) begin
         @(negedge sys_clk);
         n++;
      end
      check(16'(n), 16'(exp));
   endtask : tick_period

   task automatic give_verdict;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict

   // ----------------------------------------
   // hang guard, far above the expected run
   // ----------------------------------------
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_fail++;
         give_verdict();
      end
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (10) @(negedge sys_clk);
      sys_rst = 1'b0;
      rd(CLASS_READ, IDX_OP_STATE, OPST_STARTUP);
      rd(CLASS_READ, IDX_FLAGS, 8'h00);
      check(16'({baud_fast_r, split_thr_r}), 16'h0000);
      tick_period(int'(BAUD_LOW_DIV));
      // refusals leave state alone
      host.send(1'b0, CLASS_WRITE, IDX_SOFT_RESET, 8'h00);
      check(16'(host.got), 16'h0300);
      host.send(1'b0, CLASS_WRITE, IDX_BAUD, 8'h00);
      check(16'(host.got[9:8]), 16'h0003);
      wr(CLASS_READ, IDX_FLAGS, 8'h01, 1'b1);
      wr(CLASS_WRITE, IDX_BAUD, 8'h02, 1'b1);
      wr(CLASS_DET, IDX_SPLIT_THR, 8'h80, 1'b1);
      check(16'({baud_fast_r, split_thr_r}), 16'h0000);
      // random processing cycles, threshold varied including the edges
      for (int i = 0; i < 48; i++) begin
         if (i % 8 == 0) begin
            seed = lfsr(seed);
            thr = (i % 16 == 0) ? 7'h00 : (i == 40) ? SPLIT_THR_MAX[6:0] : seed[6:0];
            wr(CLASS_DET, IDX_SPLIT_THR, {1'b0, thr}, 1'b0);
            rd(CLASS_DET, IDX_SPLIT_THR, {1'b0, thr});
         end
         proc(8'(i % 3));
         rd(CLASS_READ, IDX_FLAGS, exp_flags(det_valid, det_forward, det_micro, det_speed));
         rd(CLASS_READ, IDX_SPEED, last_sp);
         rd(CLASS_READ, IDX_MAG, last_mg);
         rd(CLASS_READ, IDX_NOISE, noise_level);
         rd(CLASS_READ, IDX_OP_STATE, proc_state);
      end
      // potentiometer indices at the ends and at the first and ninth step boundaries, then random codes
      for (int i = 0; i < 10; i++) begin
         seed = lfsr(seed);
         hold_adc = (i < 6) ? pot_codes[i] : seed[11:0];
         sens_adc = (i < 6) ? pot_codes[5-i] : seed[23:12];
         repeat (8) @(negedge sys_clk);
         rd(CLASS_READ, IDX_HOLD_POT, exp_pot(hold_adc));
         rd(CLASS_READ, IDX_SENS_POT, exp_pot(sens_adc));
      end
      // fast rate, then software reset returns to the slow rate
      wr(CLASS_WRITE, IDX_BAUD, BAUD_SEL_HIGH, 1'b0);
      check(16'(baud_fast_r), 16'h0001);
      tick_period(int'(BAUD_HIGH_DIV));
      wr(CLASS_WRITE, IDX_SOFT_RESET, 8'h00, 1'b0);
      check(16'(soft_reset_r), 16'h0001);
      @(negedge sys_clk);
      check(16'({soft_reset_r, baud_fast_r, split_thr_r}), 16'(thr));
      rd(CLASS_READ, IDX_OP_STATE, OPST_STARTUP);
      rd(CLASS_READ, IDX_FLAGS, 8'h00);
      rd(CLASS_READ, IDX_SPEED, 8'h00);
      tick_period(int'(BAUD_LOW_DIV));
      // restore defaults clears threshold and rate
      wr(CLASS_WRITE, IDX_BAUD, BAUD_SEL_HIGH, 1'b0);
      wr(CLASS_WRITE, IDX_RESTORE, 8'h00, 1'b0);
      check(16'(restore_r), 16'h0001);
      @(negedge sys_clk);
      check(16'({restore_r, baud_fast_r, split_thr_r}), 16'h0000);
      rd(CLASS_DET, IDX_SPLIT_THR, 8'h00);
      // hardware reset in mid-run drops the fast rate again
      wr(CLASS_WRITE, IDX_BAUD, BAUD_SEL_HIGH, 1'b0);
      sys_rst = 1'b1;
      repeat (4) @(negedge sys_clk);
      sys_rst = 1'b0;
      check(16'(baud_fast_r), 16'h0000);
      rd(CLASS_READ, IDX_OP_STATE, OPST_STARTUP);
      give_verdict();
   end
endmodule : tb
